// ===== cmsw_pkg.sv
/*
 * constants shared by the message status and wake-up block:
 * register offsets, field positions, reset values, widths, state type.
 * assumes a 12-bit APB byte address window within the controller.
 */
package cmsw_pkg;

    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int NUM_OBJ   = 32;
    localparam int HALF_W    = 16;
    localparam int OBJ_IDX_W = 5;
    localparam int IRQ_W     = 2;

    // printed offsets
    localparam logic [11:0] OFS_IRQ_PEND_HI = 12'h144;
    localparam logic [11:0] OFS_VALID_LO    = 12'h160;
    localparam logic [11:0] OFS_VALID_HI    = 12'h164;
    localparam logic [11:0] OFS_WAKE_EN     = 12'h168;
    localparam logic [11:0] OFS_WAKE_STS    = 12'h16c;
    // block-local interrupt registers
    localparam logic [11:0] OFS_IRQ_STS     = 12'h170;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h174;

    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] RST_HALF  = 16'h0000;
    localparam logic [15:0] ZERO_HALF = 16'h0000;
    localparam logic [1:0]  RST_IRQ   = 2'h0;

    localparam int WAKE_EN_BIT  = 0;
    localparam int WAKE_STS_BIT = 0;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_OBJ_BIT  = 1;

    // bus receive pin idles recessive
    localparam logic RX_IDLE = 1'h1;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ACCESS
    } cmsw_apb_st_t;

endpackage

// ===== cmsw_flag_bank.sv
/*
 * one bit per message object, written one object at a time by the
 * message interface set, optionally set by hardware (set beats write).
 * assumes both ports come from logic on the same clock.
 */
module cmsw_flag_bank #(
    parameter int N     = 32,
    parameter int IDX_W = 5
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             nrst_i,
    // message interface write
    input  wire logic             wr_i,
    input  wire logic [IDX_W-1:0] wr_idx_i,
    input  wire logic             wr_val_i,
    // hardware set
    input  wire logic             set_i,
    input  wire logic [IDX_W-1:0] set_idx_i,
    // stored flags
    output logic      [N-1:0]     flags_o
);

    logic [N-1:0] next_flags;

    always_comb begin
        next_flags = flags_o;
        if (wr_i) begin
            next_flags[wr_idx_i] = wr_val_i;
        end
        if (set_i) begin
            next_flags[set_idx_i] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            flags_o <= '0;
        end else begin
            flags_o <= next_flags;
        end
    end

endmodule

// ===== cmsw_top.sv
/*
 * message object status views and bus wake-up, behind an APB slave.
 * assumes the message interface and the message handler run on
 * ref_clk_i; the bus receive pin is asynchronous and is synchronised.
 */
module cmsw_top (
    // clock and reset
    input  wire logic                               ref_clk_i,
    input  wire logic                               nrst_i,
    // apb slave
    input  wire logic                               psel_i,
    input  wire logic                               penable_i,
    input  wire logic                               pwrite_i,
    input  wire logic [cmsw_pkg::ADDR_W-1:0]        paddr_i,
    input  wire logic [cmsw_pkg::DATA_W-1:0]        pwdata_i,
    output logic      [cmsw_pkg::DATA_W-1:0]        prdata_o,
    output logic                                    pready_o,
    output logic                                    pslverr_o,
    // message interface set
    input  wire logic                               mif_wr_i,
    input  wire logic [cmsw_pkg::OBJ_IDX_W-1:0]     mif_obj_i,
    input  wire logic                               mif_valid_i,
    input  wire logic                               mif_pend_i,
    // message handler
    input  wire logic                               hndl_pend_set_i,
    input  wire logic [cmsw_pkg::OBJ_IDX_W-1:0]     hndl_obj_i,
    output logic      [cmsw_pkg::NUM_OBJ-1:0]       object_valid_flag_o,
    output logic      [cmsw_pkg::NUM_OBJ-1:0]       object_irq_pending_o,
    // can bus and system
    input  wire logic                               can_rx_i,
    output logic                                    wake_o,
    output logic                                    irq_o
);

    // apb slave state
    cmsw_pkg::cmsw_apb_st_t              st;
    cmsw_pkg::cmsw_apb_st_t              next_st;
    logic [cmsw_pkg::DATA_W-1:0]         next_prdata;
    logic                                next_pready;
    logic                                next_pslverr;
    logic                                wr_fire;
    logic                                setup;

    // control and status
    logic                                wake_function_enable;
    logic                                next_wake_function_enable;
    logic                                wake_event_flag;
    logic                                next_wake_event_flag;
    logic [cmsw_pkg::IRQ_W-1:0]          irq_sts;
    logic [cmsw_pkg::IRQ_W-1:0]          next_irq_sts;
    logic [cmsw_pkg::IRQ_W-1:0]          irq_mask;
    logic [cmsw_pkg::IRQ_W-1:0]          next_irq_mask;
    logic                                next_wake_o;
    logic                                next_irq_o;

    // receive pin synchroniser and edge
    logic                                rx_meta;
    logic                                rx_sync;
    logic                                rx_prev;
    logic                                rx_fall;
    logic                                wake_hit;

    // object flags
    logic                                hndl_ok;
    logic [cmsw_pkg::HALF_W-1:0]         pend_hi;
    logic [cmsw_pkg::HALF_W-1:0]         valid_lo;
    logic [cmsw_pkg::HALF_W-1:0]         valid_hi;

    function automatic logic addr_hit(input logic [cmsw_pkg::ADDR_W-1:0] a);
        addr_hit = (a == cmsw_pkg::OFS_IRQ_PEND_HI) || (a == cmsw_pkg::OFS_VALID_LO) ||
                   (a == cmsw_pkg::OFS_VALID_HI) || (a == cmsw_pkg::OFS_WAKE_EN) ||
                   (a == cmsw_pkg::OFS_WAKE_STS) || (a == cmsw_pkg::OFS_IRQ_STS) ||
                   (a == cmsw_pkg::OFS_IRQ_MASK);
    endfunction

    function automatic logic wr_to(input logic                          fire,
                                   input logic [cmsw_pkg::ADDR_W-1:0]   a,
                                   input logic [cmsw_pkg::ADDR_W-1:0]   ofs);
        wr_to = fire && (a == ofs);
    endfunction

    // valid flags: only the message interface writes them
    cmsw_flag_bank #(
        .N     (cmsw_pkg::NUM_OBJ),
        .IDX_W (cmsw_pkg::OBJ_IDX_W)
    ) u_valid (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .wr_i      (mif_wr_i),
        .wr_idx_i  (mif_obj_i),
        .wr_val_i  (mif_valid_i),
        .set_i     (1'b0),
        .set_idx_i (mif_obj_i),
        .flags_o   (object_valid_flag_o)
    );

    // handler may only raise pending on a configured object
    assign hndl_ok = hndl_pend_set_i && object_valid_flag_o[hndl_obj_i];

    cmsw_flag_bank #(
        .N     (cmsw_pkg::NUM_OBJ),
        .IDX_W (cmsw_pkg::OBJ_IDX_W)
    ) u_pend (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .wr_i      (mif_wr_i),
        .wr_idx_i  (mif_obj_i),
        .wr_val_i  (mif_pend_i),
        .set_i     (hndl_ok),
        .set_idx_i (hndl_obj_i),
        .flags_o   (object_irq_pending_o)
    );

    assign pend_hi  = object_irq_pending_o[31:16];
    assign valid_lo = object_valid_flag_o[15:0];
    assign valid_hi = object_valid_flag_o[31:16];

    // apb: read data is captured in the setup cycle, so no wait states
    assign setup   = psel_i && !penable_i;
    assign wr_fire = (st == cmsw_pkg::ST_ACCESS) && psel_i && penable_i && pwrite_i &&
                     !pslverr_o;

    always_comb begin
        next_st      = st;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = cmsw_pkg::RST_WORD;
        case (st)
            cmsw_pkg::ST_IDLE: begin
                if (setup) begin
                    next_st      = cmsw_pkg::ST_ACCESS;
                    next_pready  = 1'b1;
                    next_pslverr = !addr_hit(paddr_i);
                    // upper bits stay zero for every view
                    if (pwrite_i) begin
                        next_prdata = cmsw_pkg::RST_WORD;
                    end else if (paddr_i == cmsw_pkg::OFS_IRQ_PEND_HI) begin
                        next_prdata = {cmsw_pkg::ZERO_HALF, pend_hi};
                    end else if (paddr_i == cmsw_pkg::OFS_VALID_LO) begin
                        next_prdata = {cmsw_pkg::ZERO_HALF, valid_lo};
                    end else if (paddr_i == cmsw_pkg::OFS_VALID_HI) begin
                        next_prdata = {cmsw_pkg::ZERO_HALF, valid_hi};
                    end else if (paddr_i == cmsw_pkg::OFS_WAKE_EN) begin
                        next_prdata = {31'h0, wake_function_enable};
                    end else if (paddr_i == cmsw_pkg::OFS_WAKE_STS) begin
                        next_prdata = {31'h0, wake_event_flag};
                    end else if (paddr_i == cmsw_pkg::OFS_IRQ_STS) begin
                        next_prdata = {30'h0, irq_sts};
                    end else if (paddr_i == cmsw_pkg::OFS_IRQ_MASK) begin
                        next_prdata = {30'h0, irq_mask};
                    end
                end
            end
            cmsw_pkg::ST_ACCESS: begin
                next_st = cmsw_pkg::ST_IDLE;
            end
            default: begin
                next_st = cmsw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st        <= cmsw_pkg::ST_IDLE;
            prdata_o  <= cmsw_pkg::RST_WORD;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            st        <= next_st;
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // receive pin: two flops, edge seen only on synchronised copies
    assign rx_fall  = rx_prev && !rx_sync;
    assign wake_hit = wake_function_enable && rx_fall;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rx_meta <= cmsw_pkg::RX_IDLE;
            rx_sync <= cmsw_pkg::RX_IDLE;
            rx_prev <= cmsw_pkg::RX_IDLE;
        end else begin
            rx_meta <= can_rx_i;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // control/status registers; only bit 0 / low bits are stored
    always_comb begin
        next_wake_function_enable = wake_function_enable;
        next_wake_event_flag      = wake_event_flag;
        next_irq_mask             = irq_mask;
        if (wr_to(wr_fire, paddr_i, cmsw_pkg::OFS_WAKE_EN)) begin
            next_wake_function_enable = pwdata_i[cmsw_pkg::WAKE_EN_BIT];
        end
        if (wr_to(wr_fire, paddr_i, cmsw_pkg::OFS_IRQ_MASK)) begin
            next_irq_mask = pwdata_i[cmsw_pkg::IRQ_W-1:0];
        end
        // writing 0 clears; a wake edge in the same cycle still sets
        if (wr_to(wr_fire, paddr_i, cmsw_pkg::OFS_WAKE_STS) &&
            !pwdata_i[cmsw_pkg::WAKE_STS_BIT]) begin
            next_wake_event_flag = 1'b0;
        end
        if (wake_hit) begin
            next_wake_event_flag = 1'b1;
        end
        next_irq_sts = irq_sts;
        if (wr_to(wr_fire, paddr_i, cmsw_pkg::OFS_IRQ_STS)) begin
            next_irq_sts = irq_sts & ~pwdata_i[cmsw_pkg::IRQ_W-1:0];
        end
        next_irq_sts[cmsw_pkg::IRQ_WAKE_BIT] = next_irq_sts[cmsw_pkg::IRQ_WAKE_BIT] | wake_hit;
        next_irq_sts[cmsw_pkg::IRQ_OBJ_BIT]  = next_irq_sts[cmsw_pkg::IRQ_OBJ_BIT] | hndl_ok;
        next_wake_o = wake_event_flag;
        next_irq_o  = |(irq_sts & irq_mask);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            wake_function_enable <= 1'b0;
            wake_event_flag      <= 1'b0;
            irq_sts              <= cmsw_pkg::RST_IRQ;
            irq_mask             <= cmsw_pkg::RST_IRQ;
            wake_o               <= 1'b0;
            irq_o                <= 1'b0;
        end else begin
            wake_function_enable <= next_wake_function_enable;
            wake_event_flag      <= next_wake_event_flag;
            irq_sts              <= next_irq_sts;
            irq_mask             <= next_irq_mask;
            wake_o               <= next_wake_o;
            irq_o                <= next_irq_o;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_valid_ro: assert property (
        !mif_wr_i |=> $stable(object_valid_flag_o))
        else $error("valid flags changed without a message interface write");

    chk_pend_view: assert property (
        (st == cmsw_pkg::ST_IDLE && setup && !pwrite_i && paddr_i == cmsw_pkg::OFS_IRQ_PEND_HI)
        |=> pready_o && prdata_o == {cmsw_pkg::ZERO_HALF, $past(pend_hi)})
        else $error("pending view does not show objects 17 to 32");

    chk_drop_invalid: assert property (
        (hndl_pend_set_i && !object_valid_flag_o[hndl_obj_i] && !mif_wr_i)
        |=> $stable(object_irq_pending_o))
        else $error("pending set on an object that is not valid");

    chk_valid_lo: assert property (
        (st == cmsw_pkg::ST_IDLE && setup && !pwrite_i && paddr_i == cmsw_pkg::OFS_VALID_LO)
        |=> prdata_o == {cmsw_pkg::ZERO_HALF, $past(valid_lo)})
        else $error("first valid view wrong");

    chk_valid_hi: assert property (
        (st == cmsw_pkg::ST_IDLE && setup && !pwrite_i && paddr_i == cmsw_pkg::OFS_VALID_HI)
        |=> prdata_o[15] == $past(object_valid_flag_o[31]) && prdata_o[0] == $past(valid_hi[0]))
        else $error("second valid view out of object order");

    chk_wake_off: assert property (
        !wake_function_enable |=> !$rose(wake_event_flag))
        else $error("wake event raised while wake-up disabled");

    chk_wake_fall: assert property (
        (wake_function_enable && rx_prev && !rx_sync) |=> wake_event_flag ##1 wake_o)
        else $error("falling edge on receive pin did not wake");

    chk_wake_clear: assert property (
        (wr_fire && paddr_i == cmsw_pkg::OFS_WAKE_STS &&
         !pwdata_i[cmsw_pkg::WAKE_STS_BIT] && !wake_hit)
        |=> !wake_event_flag)
        else $error("writing 0 did not clear the wake event flag");

    chk_resv_zero: assert property (
        pready_o |-> prdata_o[31:16] == cmsw_pkg::ZERO_HALF)
        else $error("reserved bits read non-zero");

    chk_ctrl_resv: assert property (
        (setup && !pwrite_i && paddr_i == cmsw_pkg::OFS_WAKE_EN)
        |=> prdata_o == {31'h0, $past(wake_function_enable)})
        else $error("wake enable read shows reserved bits");

    cov_pend_read: cover property (
        setup && !pwrite_i && paddr_i == cmsw_pkg::OFS_IRQ_PEND_HI ##1 prdata_o != 32'h0);
    cov_wake: cover property (wake_hit ##2 wake_o);
    cov_irq: cover property ($rose(irq_o));
    cov_drop: cover property (
        hndl_pend_set_i && !object_valid_flag_o[hndl_obj_i]);

endmodule

// ===== cmsw_bus_model.sv
/*
 * bus side model: transceiver receive pin of the can bus.
 * assumes the bench pulses start_i for one cycle to launch a short frame.
 */
module cmsw_bus_model (
    // clock
    input  wire logic ref_clk_i,
    // bench command
    input  wire logic start_i,
    // receive pin
    output logic      can_rx_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] cnt = 4'h0;

    // dominant bits every few cycles so more than one falling edge occurs
    // plain always: the declaration value above keeps the pin recessive from time zero
    always @(posedge ref_clk_i) begin
        if (start_i) begin
            cnt <= 4'hc;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end

    // recessive (high) whenever no frame is on the wire
    assign can_rx_o = (cnt == 4'h0) ? 1'h1 : cnt[1];
endmodule

// ===== tb_cmsw_top.sv
/*
 * self-checking bench for the message status and wake-up block.
 * assumes zero or more wait states on apb; every wait is bounded.
 */
module tb_cmsw_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk_i = 1'h0;
    logic        nrst_i    = 1'h0;
    logic        psel_i    = 1'h0;
    logic        penable_i = 1'h0;
    logic        pwrite_i  = 1'h0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        mif_wr_i  = 1'h0;
    logic [4:0]  mif_obj_i = 5'h00;
    logic        mif_valid_i = 1'h0;
    logic        mif_pend_i  = 1'h0;
    logic        hndl_pend_set_i = 1'h0;
    logic [4:0]  hndl_obj_i = 5'h00;
    logic [31:0] object_valid_flag_o;
    logic [31:0] object_irq_pending_o;
    logic        can_rx_i;
    logic        wake_o;
    logic        irq_o;
    logic        frame_go  = 1'h0;
    int          error_cnt = 0;
    int          n_tests   = 0;

    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    cmsw_top dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .mif_wr_i(mif_wr_i), .mif_obj_i(mif_obj_i), .mif_valid_i(mif_valid_i),
        .mif_pend_i(mif_pend_i), .hndl_pend_set_i(hndl_pend_set_i), .hndl_obj_i(hndl_obj_i),
        .object_valid_flag_o(object_valid_flag_o),
        .object_irq_pending_o(object_irq_pending_o), .can_rx_i(can_rx_i),
        .wake_o(wake_o), .irq_o(irq_o));

    cmsw_bus_model bus (.ref_clk_i(ref_clk_i), .start_i(frame_go), .can_rx_o(can_rx_i));

    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge ref_clk_i);
        psel_i    <= 1'h1;
        penable_i <= 1'h0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'h1;
        i = 0;
        do begin
            @(posedge ref_clk_i);
            i++;
        end while (pready_o !== 1'h1 && i < 20);
        r = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'h0;
        penable_i <= 1'h0;
        if (i >= 20) begin
            error_cnt++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask

    task automatic mif(input logic [4:0] o, input logic v, input logic p);
        @(posedge ref_clk_i);
        mif_wr_i    <= 1'h1;
        mif_obj_i   <= o;
        mif_valid_i <= v;
        mif_pend_i  <= p;
        @(posedge ref_clk_i);
        mif_wr_i    <= 1'h0;
    endtask

    task automatic hndl(input logic [4:0] o);
        @(posedge ref_clk_i);
        hndl_pend_set_i <= 1'h1;
        hndl_obj_i      <= o;
        @(posedge ref_clk_i);
        hndl_pend_set_i <= 1'h0;
    endtask

    task automatic frame();
        @(posedge ref_clk_i);
        frame_go <= 1'h1;
        @(posedge ref_clk_i);
        frame_go <= 1'h0;
        repeat (16) @(posedge ref_clk_i);
    endtask

    task automatic test_reset_map();
        rd(12'h144, 32'h0, 1'h0);
        rd(12'h160, 32'h0, 1'h0);
        rd(12'h164, 32'h0, 1'h0);
        rd(12'h168, 32'h0, 1'h0);
        rd(12'h200, 32'h0, 1'h1);
        rd(12'h161, 32'h0, 1'h1);
        $display("test reset_map done");
    endtask

    task automatic test_valid();
        mif(5'd0, 1'h1, 1'h0);
        mif(5'd15, 1'h1, 1'h0);
        mif(5'd16, 1'h1, 1'h0);
        mif(5'd31, 1'h1, 1'h0);
        mif(5'd15, 1'h0, 1'h0);
        @(posedge ref_clk_i);
        chk(object_valid_flag_o, 32'h8001_0001);
        wr(12'h160, 32'hffff_ffff);
        wr(12'h164, 32'h0000_0000);
        rd(12'h160, 32'h0000_0001, 1'h0);
        rd(12'h164, 32'h0000_8001, 1'h0);
        $display("test valid done");
    endtask

    task automatic test_pending();
        hndl(5'd16);
        hndl(5'd20);
        hndl(5'd1);
        @(posedge ref_clk_i);
        chk(object_irq_pending_o, 32'h0001_0000);
        wr(12'h144, 32'hffff_ffff);
        rd(12'h144, 32'h0000_0001, 1'h0);
        mif(5'd31, 1'h1, 1'h1);
        rd(12'h144, 32'h0000_8001, 1'h0);
        $display("test pending done");
    endtask

    task automatic test_wake();
        frame();
        chk({31'h0, wake_o}, 32'h0);
        rd(12'h16c, 32'h0, 1'h0);
        wr(12'h168, 32'hffff_ffff);
        rd(12'h168, 32'h0000_0001, 1'h0);
        frame();
        chk({31'h0, wake_o}, 32'h1);
        rd(12'h16c, 32'h0000_0001, 1'h0);
        wr(12'h16c, 32'h0000_0001);
        rd(12'h16c, 32'h0000_0001, 1'h0);
        wr(12'h174, 32'h0000_0001);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wr(12'h16c, 32'h0);
        rd(12'h16c, 32'h0, 1'h0);
        chk({31'h0, wake_o}, 32'h0);
        wr(12'h170, 32'h0000_0001);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wr(12'h174, 32'h0000_0003);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wr(12'h170, 32'h0000_0003);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        $display("test wake done");
    endtask

    // second reset in mid-run: flags and enable set earlier must come back as zero
    task automatic test_reset_mid();
        @(posedge ref_clk_i);
        nrst_i <= 1'h0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'h1;
        @(posedge ref_clk_i);
        chk(object_valid_flag_o, 32'h0);
        chk(object_irq_pending_o, 32'h0);
        chk({31'h0, wake_o}, 32'h0);
        rd(12'h168, 32'h0, 1'h0);
        rd(12'h164, 32'h0, 1'h0);
        rd(12'h144, 32'h0, 1'h0);
        $display("test reset_mid done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_i);
        nrst_i <= 1'h1;
        test_reset_map();
        test_valid();
        test_pending();
        test_wake();
        test_reset_mid();
        stop_test();
    end
endmodule
